//--- verilog/swc_pkg.sv
// swc_pkg: shared constants and types of the sleep and wakeup controller
// assumes a 32-bit AXI4-Lite register port and one core clock
package swc_pkg;
   localparam int         ADDR_W        = 4;
   localparam int         SYNC_STAGES   = 3;

   // register byte offsets
   localparam logic [3:0] CTRL_OFF      = 4'h0;
   localparam logic [3:0] STAT_OFF      = 4'h4;

   // control register field positions
   localparam int         ONRET_BIT     = 1;
   localparam int         DEEP_BIT      = 2;
   localparam int         PEND_BIT      = 4;

   // status register field positions
   localparam int         STAT_SLP_BIT  = 0;
   localparam int         STAT_EVT_BIT  = 1;
   localparam int         STAT_DEEP_BIT = 2;

   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum {ST_RUN, ST_SLP_INT, ST_SLP_EVT} swc_state_t;

   typedef struct packed {
      logic eventOnPend;
      logic deepSleepSelect;
      logic sleepOnReturn;
   } swc_ctrl_t;

   localparam swc_ctrl_t  CTRL_RST      = '0;

   typedef struct packed {
      logic procClkStop;
      logic sysClkStop;
      logic pllOff;
      logic flashOff;
   } swc_pwr_t;

   localparam swc_pwr_t   PWR_RST       = '0;

   // one-cycle instruction and status strobes from the core pipeline
   typedef struct packed {
      logic waitIntInsn;
      logic waitEvtInsn;
      logic sendEvtInsn;
      logic lastExit;
      logic excTakeable;
      logic irqAbove;
      logic newPend;
   } swc_core_t;
endpackage

//--- verilog/swc_axil_regs.sv
// swc_axil_regs: AXI4-Lite slave holding the control word and reading back the status word
// assumes all channels on core_clk; clkEn low freezes every flop
`timescale 1ns/100ps
`default_nettype none
module swc_axil_regs (
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       clkEn,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [swc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic [1:0]                      bresp,
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [swc_pkg::ADDR_W-1:0] araddr,
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output swc_pkg::swc_ctrl_t              sysCtrlReg,
   input  wire logic [31:0]                statusWord
);
   // bit 0: control word hit, bit 1: status word hit
   function automatic logic [1:0] regDecode(input logic [swc_pkg::ADDR_W-1:0] a);
      regDecode = {a == swc_pkg::STAT_OFF, a == swc_pkg::CTRL_OFF};
   endfunction

   logic                      awHave, next_awHave, wHave, next_wHave;
   logic [swc_pkg::ADDR_W-1:0] awAddrQ, next_awAddrQ;
   logic [7:0]                wByte, next_wByte;
   logic                      wLane, next_wLane;
   logic                      next_bvalid, next_rvalid;
   logic [1:0]                next_bresp, next_rresp, wSel;
   logic [31:0]               next_rdata;
   swc_pkg::swc_ctrl_t        next_ctrl;

   assign awready = clkEn & ~awHave & ~bvalid;
   assign wready  = clkEn & ~wHave & ~bvalid;
   assign arready = clkEn & ~rvalid;

   always_comb begin
      next_awHave  = awHave | (awvalid & awready);
      next_wHave   = wHave | (wvalid & wready);
      next_awAddrQ = awHave ? awAddrQ : awaddr;
      next_wByte   = wHave ? wByte : wdata[7:0];
      next_wLane   = wHave ? wLane : wstrb[0];
      next_bvalid  = bvalid & ~(bready & clkEn);
      next_bresp   = bresp;
      next_rvalid  = rvalid & ~(rready & clkEn);
      next_rdata   = rdata;
      next_rresp   = rresp;
      next_ctrl    = sysCtrlReg;
      wSel         = regDecode(next_awAddrQ);
      if (next_awHave && next_wHave && !bvalid) begin
         next_awHave = 1'b0;
         next_wHave  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = |wSel ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
         if (wSel[0] && next_wLane) begin
            next_ctrl.sleepOnReturn   = next_wByte[swc_pkg::ONRET_BIT];
            next_ctrl.deepSleepSelect = next_wByte[swc_pkg::DEEP_BIT];
            next_ctrl.eventOnPend     = next_wByte[swc_pkg::PEND_BIT];
         end
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = |regDecode(araddr) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
         next_rdata  = 32'h0;
         if (regDecode(araddr) == 2'h1) begin
            next_rdata[swc_pkg::ONRET_BIT] = sysCtrlReg.sleepOnReturn;
            next_rdata[swc_pkg::DEEP_BIT]  = sysCtrlReg.deepSleepSelect;
            next_rdata[swc_pkg::PEND_BIT]  = sysCtrlReg.eventOnPend;
         end else if (regDecode(araddr) == 2'h2) begin
            next_rdata = statusWord;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awHave     <= 1'b0;
         wHave      <= 1'b0;
         awAddrQ    <= '0;
         wByte      <= 8'h00;
         wLane      <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= swc_pkg::RESP_OKAY;
         rvalid     <= 1'b0;
         rdata      <= 32'h0;
         rresp      <= swc_pkg::RESP_OKAY;
         sysCtrlReg <= swc_pkg::CTRL_RST;
      end else if (clkEn) begin
         awHave     <= next_awHave;
         wHave      <= next_wHave;
         awAddrQ    <= next_awAddrQ;
         wByte      <= next_wByte;
         wLane      <= next_wLane;
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         rvalid     <= next_rvalid;
         rdata      <= next_rdata;
         rresp      <= next_rresp;
         sysCtrlReg <= next_ctrl;
      end
   end
endmodule // swc_axil_regs
`default_nettype wire

//--- verilog/swc_sleep_ctrl.sv
// swc_sleep_ctrl: sleep entry, event latch and wakeup sequencing of one core
// assumes core strobes on core_clk; extEvent and sendEvtIn are asynchronous
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module swc_sleep_ctrl (
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       clkEn,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [swc_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic [1:0]                      bresp,
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [swc_pkg::ADDR_W-1:0] araddr,
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   input  wire swc_pkg::swc_core_t         coreIn,
   input  wire logic                       priorityMask,
   input  wire logic                       faultMaskA,
   input  wire logic                       extEvent,
   input  wire logic                       sendEvtIn,
   output logic                            sendEvtOut,
   output swc_pkg::swc_pwr_t               pwrCtl,
   output logic                            wakePulse,
   output logic                            handlerDefer
);
   swc_pkg::swc_ctrl_t  sysCtrlReg;
   logic [31:0]         statusWord;

   swc_pkg::swc_state_t state, next_state;
   swc_pkg::swc_pwr_t   next_pwr;
   logic                evLatch, next_evLatch;
   logic                deepMode, next_deepMode;
   logic                next_defer, next_wake, next_sevOut;
   logic [1:0]          pinIn, pinRise;
   logic                maskWake, wakeInt, evNow, evtWake;

   swc_axil_regs uRegs (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .clkEn      (clkEn),
      .awvalid    (awvalid),
      .awready    (awready),
      .awaddr     (awaddr),
      .wvalid     (wvalid),
      .wready     (wready),
      .wdata      (wdata),
      .wstrb      (wstrb),
      .bvalid     (bvalid),
      .bready     (bready),
      .bresp      (bresp),
      .arvalid    (arvalid),
      .arready    (arready),
      .araddr     (araddr),
      .rvalid     (rvalid),
      .rready     (rready),
      .rdata      (rdata),
      .rresp      (rresp),
      .sysCtrlReg (sysCtrlReg),
      .statusWord (statusWord)
   );

   // peripheral event pin and other cores' send-event line
   assign pinIn = {sendEvtIn, extEvent};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : gSync
         logic [swc_pkg::SYNC_STAGES-1:0] sh, next_sh;
         logic                            filt, next_filt;
         always_comb begin
            next_sh   = {sh[swc_pkg::SYNC_STAGES-2:0], pinIn[gi]};
            next_filt = (sh[1] == sh[2]) ? sh[2] : filt;
         end
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               sh   <= '0;
               filt <= 1'b0;
            end else if (clkEn) begin
               sh   <= next_sh;
               filt <= next_filt;
            end
         end
         // a rising level counts once, when the last two stages agree
         assign pinRise[gi] = clkEn & (sh[1] == sh[2]) & sh[2] & ~filt;
      end
   endgenerate

   assign maskWake = priorityMask & ~faultMaskA & coreIn.irqAbove;
   assign wakeInt  = coreIn.excTakeable | maskWake;
   assign evNow    = pinRise[0] | pinRise[1] | coreIn.sendEvtInsn
                   | (sysCtrlReg.eventOnPend & coreIn.newPend);
   assign evtWake  = wakeInt | evNow;

   always_comb begin
      next_state    = state;
      next_evLatch  = evLatch;
      next_deepMode = deepMode;
      next_defer    = handlerDefer;
      next_wake     = wakePulse;
      next_sevOut   = sendEvtOut;
      next_pwr      = pwrCtl;
      if (clkEn) begin
         next_wake    = 1'b0;
         next_sevOut  = coreIn.sendEvtInsn;
         next_evLatch = evLatch | evNow;
         if (!priorityMask) begin
            next_defer = 1'b0;
         end
         unique case (state)
            swc_pkg::ST_RUN: begin
               if (coreIn.waitEvtInsn) begin
                  if (evLatch || evNow) begin
                     // a fresh event in the clearing cycle survives
                     next_evLatch = evLatch & evNow;
                  end else begin
                     next_state = swc_pkg::ST_SLP_EVT;
                  end
               end else if (coreIn.waitIntInsn && !wakeInt) begin
                  next_state = swc_pkg::ST_SLP_INT;
               end else if (coreIn.lastExit && sysCtrlReg.sleepOnReturn && !wakeInt) begin
                  next_state = swc_pkg::ST_SLP_INT;
               end
               next_deepMode = sysCtrlReg.deepSleepSelect;
            end
            swc_pkg::ST_SLP_INT: begin
               if (wakeInt) begin
                  next_state = swc_pkg::ST_RUN;
                  next_wake  = 1'b1;
                  next_defer = priorityMask & ~faultMaskA;
               end
            end
            swc_pkg::ST_SLP_EVT: begin
               // the waking event is consumed, not latched
               next_evLatch = evLatch;
               if (evtWake) begin
                  next_state = swc_pkg::ST_RUN;
                  next_wake  = 1'b1;
                  next_defer = priorityMask & ~faultMaskA;
               end
            end
         endcase
         next_pwr.procClkStop = next_state != swc_pkg::ST_RUN;
         next_pwr.sysClkStop  = next_pwr.procClkStop & next_deepMode;
         next_pwr.pllOff      = next_pwr.procClkStop & next_deepMode;
         next_pwr.flashOff    = next_pwr.procClkStop & next_deepMode;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state        <= swc_pkg::ST_RUN;
         evLatch      <= 1'b0;
         deepMode     <= 1'b0;
         handlerDefer <= 1'b0;
         wakePulse    <= 1'b0;
         sendEvtOut   <= 1'b0;
         pwrCtl       <= swc_pkg::PWR_RST;
      end else begin
         state        <= next_state;
         evLatch      <= next_evLatch;
         deepMode     <= next_deepMode;
         handlerDefer <= next_defer;
         wakePulse    <= next_wake;
         sendEvtOut   <= next_sevOut;
         pwrCtl       <= next_pwr;
      end
   end

   // the event latch is deliberately absent from the status word
   always_comb begin
      statusWord                         = 32'h0;
      statusWord[swc_pkg::STAT_SLP_BIT]  = pwrCtl.procClkStop;
      statusWord[swc_pkg::STAT_EVT_BIT]  = state == swc_pkg::ST_SLP_EVT;
      statusWord[swc_pkg::STAT_DEEP_BIT] = pwrCtl.sysClkStop;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   light_only_a: assert property (
      pwrCtl.procClkStop && !deepMode |-> !pwrCtl.sysClkStop && !pwrCtl.pllOff)
      else $error("light sleep touched system clock or pll");

   deep_all_a: assert property (
      state != swc_pkg::ST_RUN && deepMode
      |-> pwrCtl.sysClkStop && pwrCtl.pllOff && pwrCtl.flashOff && pwrCtl.procClkStop)
      else $error("deep sleep left a domain powered");

   int_sleep_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitIntInsn && !coreIn.waitEvtInsn
      && !wakeInt |=> state == swc_pkg::ST_SLP_INT && pwrCtl.procClkStop)
      else $error("wait for interrupt did not sleep");

   int_cont_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitIntInsn && !coreIn.waitEvtInsn
      && wakeInt |=> state == swc_pkg::ST_RUN)
      else $error("wait for interrupt slept despite wakeup");

   evt_clear_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitEvtInsn && evLatch && !evNow
      |=> state == swc_pkg::ST_RUN && !evLatch)
      else $error("set latch not consumed by wait for event");

   evt_sleep_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitEvtInsn && !evLatch && !evNow
      |=> state == swc_pkg::ST_SLP_EVT)
      else $error("wait for event with clear latch did not sleep");

   latch_set_a: assert property (
      clkEn && evNow && state != swc_pkg::ST_SLP_EVT && !coreIn.waitEvtInsn
      |=> evLatch)
      else $error("event did not set the latch");

   pin_event_a: assert property (
      clkEn && pinRise[0] && state == swc_pkg::ST_SLP_EVT
      |=> state == swc_pkg::ST_RUN && wakePulse)
      else $error("pin event did not wake from wait for event");

   ret_sleep_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.lastExit && sysCtrlReg.sleepOnReturn
      && !coreIn.waitEvtInsn && !wakeInt |=> state == swc_pkg::ST_SLP_INT)
      else $error("return to thread did not sleep");

   int_hold_a: assert property (
      state == swc_pkg::ST_SLP_INT && !(clkEn && wakeInt)
      |=> state == swc_pkg::ST_SLP_INT && !wakePulse)
      else $error("woke without an enterable exception");

   defer_a: assert property (
      clkEn && state == swc_pkg::ST_SLP_INT && maskWake && !faultMaskA
      |=> wakePulse && handlerDefer ##1 (handlerDefer || !$past(priorityMask)))
      else $error("masked wakeup not deferred");

   evt_wake_a: assert property (
      clkEn && state == swc_pkg::ST_SLP_EVT && evtWake
      |=> state == swc_pkg::ST_RUN && wakePulse && !pwrCtl.procClkStop)
      else $error("wait for event sleep missed a wake cause");

   pend_wake_a: assert property (
      clkEn && state == swc_pkg::ST_SLP_EVT && sysCtrlReg.eventOnPend && coreIn.newPend
      |=> state == swc_pkg::ST_RUN)
      else $error("new pending interrupt did not wake");

   rst_latch_a: assert property (
      $rose(resetn) |-> !evLatch && state == swc_pkg::ST_RUN)
      else $error("latch not clear after reset");

   // freeze, pulse and latch retention
   latch_hold_a: assert property (
      !(clkEn && (evNow || coreIn.waitEvtInsn))
      |=> $stable(evLatch))
      else $error("event latch changed without an event or wait");

   set_wins_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitEvtInsn && evLatch && evNow
      |=> state == swc_pkg::ST_RUN && evLatch)
      else $error("event in the clearing cycle was lost");

   evt_absorb_a: assert property (
      clkEn && state == swc_pkg::ST_RUN && coreIn.waitEvtInsn && !evLatch && evNow
      |=> state == swc_pkg::ST_RUN && !evLatch)
      else $error("event beside wait for event mishandled");

   evt_consume_a: assert property (
      state == swc_pkg::ST_SLP_EVT
      |-> !evLatch)
      else $error("latch set during wait for event sleep");

   evt_stay_a: assert property (
      clkEn && state == swc_pkg::ST_SLP_EVT && !evtWake
      |=> state == swc_pkg::ST_SLP_EVT && pwrCtl.procClkStop)
      else $error("wait for event sleep ended without a cause");

   wake_state_a: assert property (
      wakePulse
      |-> state == swc_pkg::ST_RUN && !pwrCtl.procClkStop)
      else $error("wake pulse while still asleep");

   wake_once_a: assert property (
      clkEn && wakePulse
      |=> !wakePulse)
      else $error("wake pulse longer than one cycle");

   defer_clear_a: assert property (
      clkEn && !priorityMask
      |=> !handlerDefer)
      else $error("handler still deferred after mask cleared");

   sev_out_a: assert property (
      clkEn && coreIn.sendEvtInsn
      |=> sendEvtOut)
      else $error("send event not forwarded");

   run_awake_a: assert property (
      state == swc_pkg::ST_RUN
      |-> !pwrCtl.procClkStop)
      else $error("core clock stopped while running");

   deep_hold_a: assert property (
      state != swc_pkg::ST_RUN
      |=> $stable(deepMode))
      else $error("sleep depth changed while asleep");

   light_flash_a: assert property (
      pwrCtl.procClkStop && !deepMode
      |-> !pwrCtl.flashOff)
      else $error("light sleep switched flash off");

   freeze_a: assert property (
      !clkEn
      |=> $stable(state) && $stable(pwrCtl) && $stable(handlerDefer))
      else $error("state moved while clock enable low");

   evt_cycle_c: cover property (
      state == swc_pkg::ST_SLP_EVT ##1 state == swc_pkg::ST_SLP_EVT ##1 wakePulse);
   deep_sleep_c: cover property (
      $rose(pwrCtl.sysClkStop) ##[1:20] $fell(pwrCtl.sysClkStop));
   ret_sleep_c: cover property (
      clkEn && coreIn.lastExit && sysCtrlReg.sleepOnReturn ##1 state == swc_pkg::ST_SLP_INT);
   skip_sleep_c: cover property (
      clkEn && coreIn.waitEvtInsn && evLatch && state == swc_pkg::ST_RUN);
   defer_wake_c: cover property (
      wakePulse && handlerDefer);
endmodule // swc_sleep_ctrl
`default_nettype wire

//--- testbench/swc_event_src.sv
// swc_event_src: peripheral and remote-core event sources facing the sleep controller
// assumes one-cycle request strobes on core_clk; each line is driven low when idle
`timescale 1ns/100ps
`default_nettype none
module swc_event_src #(
   parameter int HOLD = 4
) (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic extReq,
   input  wire logic sevReq,
   output logic      extEvent,
   output logic      sendEvtIn
);
   logic [3:0] extCnt;
   logic [3:0] sevCnt;
   logic [3:0] next_extCnt;
   logic [3:0] next_sevCnt;

   // lines stay high long enough for the pin synchroniser to see a rise
   always_comb begin
      next_extCnt = extReq ? 4'(HOLD) : extCnt - {3'h0, (extCnt != 4'h0)};
      next_sevCnt = sevReq ? 4'(HOLD) : sevCnt - {3'h0, (sevCnt != 4'h0)};
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         extCnt <= 4'h0;
         sevCnt <= 4'h0;
      end else begin
         extCnt <= next_extCnt;
         sevCnt <= next_sevCnt;
      end
   end

   assign extEvent  = (extCnt != 4'h0);
   assign sendEvtIn = (sevCnt != 4'h0);
endmodule // swc_event_src
`default_nettype wire

//--- testbench/tb.sv
// tb: self-checking bench for the sleep and wakeup controller
// assumes swc_pkg and the design files are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [6:0] W_INT = 7'h40;
   localparam logic [6:0] W_EVT = 7'h20;
   localparam logic [6:0] SEND_EVENT_INSN   = 7'h10;
   localparam logic [6:0] LEXIT = 7'h08;
   localparam logic [3:0] LIGHT = 4'h8;
   localparam logic [3:0] DEEP  = 4'hf;
   logic core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sendEvtOut, wakePulse, handlerDefer;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic priorityMask = 1'b0, faultMaskA = 1'b0, extReq = 1'b0, sevReq = 1'b0;
   logic extEvent, sendEvtIn;
   swc_pkg::swc_core_t core = '0;
   swc_pkg::swc_pwr_t  pwrCtl;
   int errors = 0, compares = 0;

   always #2.5 core_clk = ~core_clk;

   swc_sleep_ctrl i_swc_sleep_ctrl (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .coreIn(core), .priorityMask(priorityMask),
      .faultMaskA(faultMaskA), .extEvent(extEvent), .sendEvtIn(sendEvtIn),
      .sendEvtOut(sendEvtOut), .pwrCtl(pwrCtl), .wakePulse(wakePulse),
      .handlerDefer(handlerDefer));

   swc_event_src i_swc_event_src (.core_clk(core_clk), .resetn(resetn), .extReq(extReq),
      .sevReq(sevReq), .extEvent(extEvent), .sendEvtIn(sendEvtIn));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // every bus and strobe task starts and ends just after a rising edge
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge core_clk);
   endtask

   task automatic axiRead(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge core_clk);
   endtask

   // one-cycle core strobe, then the power outputs one edge later
   task automatic strobe(input logic [6:0] m, input logic [3:0] expPwr);
      core <= swc_pkg::swc_core_t'(core | m);
      @(posedge core_clk);
      core <= swc_pkg::swc_core_t'(core & ~m);
      @(posedge core_clk);
      chk({28'h0, pwrCtl}, {28'h0, expPwr});
   endtask

   task automatic waitWake(input int lim, input logic exp);
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < lim && !seen; n++) begin
         @(posedge core_clk);
         if (n == 0) begin
            extReq <= 1'b0; sevReq <= 1'b0; core.newPend <= 1'b0;
         end
         if (wakePulse === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen}, {31'h0, exp});
      if (exp) chk({28'h0, pwrCtl}, 32'h0);
   endtask

   initial begin
      #25000;
      errors++;
      test_done;
   end

   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      axiRead(swc_pkg::CTRL_OFF, 32'h0, swc_pkg::RESP_OKAY);
      axiRead(swc_pkg::STAT_OFF, 32'h0, swc_pkg::RESP_OKAY);
      axiRead(4'h8, 32'h0, swc_pkg::RESP_SLVERR);
      axiWrite(4'hc, 32'hffffffff, swc_pkg::RESP_SLVERR);
      axiWrite(swc_pkg::STAT_OFF, 32'hffffffff, swc_pkg::RESP_OKAY);
      axiRead(swc_pkg::CTRL_OFF, 32'h0, swc_pkg::RESP_OKAY);
      strobe(W_EVT, LIGHT);
      axiRead(swc_pkg::STAT_OFF, 32'h3, swc_pkg::RESP_OKAY);
      extReq <= 1'b1;
      waitWake(20, 1'b1);
      extReq <= 1'b1;
      @(posedge core_clk);
      extReq <= 1'b0;
      repeat (9) @(posedge core_clk);
      strobe(W_EVT, 4'h0);
      strobe(W_EVT, LIGHT);
      sevReq <= 1'b1;
      waitWake(20, 1'b1);
      strobe(SEND_EVENT_INSN, 4'h0);
      chk({31'h0, sendEvtOut}, 32'h1);
      strobe(W_EVT | SEND_EVENT_INSN, 4'h0);
      strobe(W_EVT, 4'h0);
      strobe(W_EVT | SEND_EVENT_INSN, 4'h0);
      axiWrite(swc_pkg::CTRL_OFF, 32'h10, swc_pkg::RESP_OKAY);
      strobe(W_EVT, LIGHT);
      core.newPend <= 1'b1;
      waitWake(20, 1'b1);
      axiWrite(swc_pkg::CTRL_OFF, 32'h4, swc_pkg::RESP_OKAY);
      axiRead(swc_pkg::CTRL_OFF, 32'h4, swc_pkg::RESP_OKAY);
      strobe(W_INT, DEEP);
      axiRead(swc_pkg::STAT_OFF, 32'h5, swc_pkg::RESP_OKAY);
      extReq <= 1'b1;
      waitWake(12, 1'b0);
      core.excTakeable <= 1'b1;
      waitWake(20, 1'b1);
      strobe(W_INT, 4'h0);
      core.excTakeable <= 1'b0;
      axiWrite(swc_pkg::CTRL_OFF, 32'h2, swc_pkg::RESP_OKAY);
      priorityMask <= 1'b1;
      strobe(LEXIT, LIGHT);
      core.irqAbove <= 1'b1;
      waitWake(20, 1'b1);
      @(posedge core_clk);
      chk({31'h0, handlerDefer}, 32'h1);
      priorityMask <= 1'b0;
      core.irqAbove <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({31'h0, handlerDefer}, 32'h0);
      clkEn <= 1'b0;
      strobe(W_INT, 4'h0);
      clkEn <= 1'b1;
      strobe(W_INT, LIGHT);
      test_done;
   end
endmodule // tb
`default_nettype wire
